// ==== mbp_pkg.sv ====
// package: constants and carriers for the translation/protection cache block
package mbp_pkg;
	localparam int KEY_W = 4;
	localparam int SET_W = 4;
	localparam int PAGE_W = 4;
	localparam int OFS_W = 12;
	localparam int PPA_W = 8;
	localparam int PREG_W = PPA_W + KEY_W + 2;
	localparam int NREG = 512;
	localparam int NREG_W = 9;
	localparam int PHYS_W = PPA_W + OFS_W;
	localparam int PWORD_N = 64;
	localparam int PWORD_W = 6;
	localparam int BLK_LSB = 14;
	localparam int SUB_LSB = 10;
	localparam logic [3:0] KEY_ANY = 4'h0;
	localparam logic [3:0] LOCK_OPEN = 4'hF;
	localparam logic [PPA_W-1:0] RST_PPA = 8'h00;

	// page register: ppa, lock, write/exec inhibit, parity
	typedef struct packed {
		logic [PPA_W-1:0] ppa;
		logic [KEY_W-1:0] lock;
		logic inhibit;
		logic parity;
	} mbp_preg_t;

	typedef struct packed {
		logic valid;
		logic [NREG_W-1:0] tag;
		mbp_preg_t data;
	} mbp_tcache_t;

	typedef struct packed {
		logic dma;
		logic read;
		logic operand;
		logic memory;
		logic [SET_W-1:0] state;
		logic [KEY_W-1:0] key;
		logic [15:0] addr;
	} mbp_req_t;
endpackage : mbp_pkg

// ==== mbp_key_check.sv ====
// key against lock comparison
`timescale 1ns/1ps
`default_nettype none
module mbp_key_check import mbp_pkg::*; (
	input wire logic [KEY_W-1:0] i_key,
	input wire logic [KEY_W-1:0] i_lock,
	output logic o_ok
);
	// key zero always passes, open lock takes any key
	assign o_ok = (i_key == KEY_ANY) || (i_lock == LOCK_OPEN) ||
		(i_key == i_lock); // [RULE15]
endmodule : mbp_key_check
`default_nettype wire

// ==== mbp_cache_protect.sv ====
// translation and protection caches with protect outputs
// Notes on behaviour
// RULE1 - dma master drives address state and key during its accesses
// RULE2 - two translation caches: operand and instruction, picked by select
// RULE3 - under dma the caches serve reads and writes, picked by direction
// RULE4 - page miss adds one wait while cache reloads from page memory
// RULE5 - protection word cached; new 16k block adds one wait
// RULE6 - address from translation cache, protection from protection cache
// RULE7 - parity error output low on page register parity fault
// RULE8 - no parity checking on command cycles
// RULE9 - protect output low whenever address strobe is low
// RULE10 - translation only: output low until valid, stays low if invalid
// RULE11 - both: rises only if translation valid and block unprotected
// RULE12 - protection only: output shows the block protection bit
// RULE13 - system gates protect output with protect valid low
// RULE14 - protect valid falls when result valid, stays high with no protection
// RULE15 - key zero passes, lock f passes all, else key must equal lock
// RULE16 - each protection bit guards 1k words; writes there violate
// RULE17 - master drives select high for operand, low for instruction
// RULE18 - master drives direction high on read, low on write
// RULE19 - rewriting a page register or protection word invalidates caches; code checks the pre-edge tag, missing a same-cycle fill of that index
`timescale 1ns/1ps
`default_nettype none
module mbp_cache_protect import mbp_pkg::*; #(
	parameter bit HAS_XLAT = 1'b1,
	parameter bit HAS_PROT = 1'b1
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_address_strobe_in,
	input wire logic i_memory_sel,
	input wire logic i_read_write_select,
	input wire logic i_operand_instruction_select,
	input wire logic i_dma,
	input wire logic [SET_W-1:0] i_address_state,
	input wire logic [KEY_W-1:0] i_processor_state_key,
	input wire logic [15:0] i_addr,
	input wire logic [PHYS_W-1:0] i_phys_ext,
	input wire logic i_preg_we,
	input wire logic [NREG_W-1:0] i_preg_idx,
	input wire logic [PREG_W-1:0] i_preg_data,
	input wire logic i_pword_we,
	input wire logic [PWORD_W-1:0] i_pword_idx,
	input wire logic [15:0] i_pword_data,
	output logic o_memory_protect_out_n,
	output logic o_parity_error_out_n,
	output logic o_protect_valid_n,
	output logic o_wait,
	output logic [PHYS_W-1:0] o_phys_addr
);
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_XLAT = 5'b00010,
		ST_TFILL = 5'b00100,
		ST_PFILL = 5'b01000,
		ST_DONE = 5'b10000
	} mbp_state_t;

	// strobe, request pins and external address pass two flops before any logic; loader write pins are used directly
	logic [1:0] as_sy;
	logic [$bits(mbp_req_t)-1:0] rq_s1, rq_s2;
	logic [PHYS_W-1:0] px_s1, px_s2;
	mbp_req_t rq;
	mbp_state_t state, next_state;
	mbp_preg_t pmem [NREG];
	logic [15:0] wmem [PWORD_N];
	mbp_tcache_t tc [2];
	logic pc_valid;
	logic [PWORD_W-1:0] pc_tag;
	logic [15:0] pc_word;
	logic sel, ok_key, nprot, fault;

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			as_sy <= 2'b00;
			rq_s1 <= '0;
			rq_s2 <= '0;
			px_s1 <= '0;
			px_s2 <= '0;
		end else begin
			as_sy <= {as_sy[0], i_address_strobe_in};
			rq_s1 <= {i_dma, i_read_write_select, i_operand_instruction_select,
				i_memory_sel, i_address_state, i_processor_state_key, i_addr};
			rq_s2 <= rq_s1;
			px_s1 <= i_phys_ext;
			px_s2 <= px_s1;
		end
	end
	assign rq = mbp_req_t'(rq_s2);
	wire as_hi = as_sy[1];

	// cpu: operand/instruction; dma: read/write picks the cache
	assign sel = rq.dma ? rq.read : rq.operand; // [RULE2] [RULE3]
	wire [NREG_W-1:0] pidx = {rq.state, rq.operand, rq.addr[15:12]};
	wire t_hit = tc[sel].valid && (tc[sel].tag == pidx); // [RULE4]
	mbp_preg_t pe;
	assign pe = tc[sel].data;
	// physical address from translation cache, else from the pins after two flops
	wire [PHYS_W-1:0] phys = HAS_XLAT ? {pe.ppa, rq.addr[OFS_W-1:0]}
		: px_s2; // [RULE6]
	wire [PWORD_W-1:0] pw_idx = phys[PHYS_W-1:BLK_LSB];
	wire [3:0] sub = phys[BLK_LSB-1:SUB_LSB];
	wire p_hit = pc_valid && (pc_tag == pw_idx); // [RULE5]
	// msb guards the lowest 1k block
	wire prot_bit = pc_word[4'hF - sub] && !rq.read; // [RULE16]
	wire par_bad = ^{pe.ppa, pe.lock, pe.inhibit} != pe.parity;
	// inhibit: no writes to operand pages, no fetch from instruction pages
	wire inh = pe.inhibit && (rq.operand ? !rq.read : 1'b1);

	mbp_key_check u_key (
		.i_key(rq.key),
		.i_lock(pe.lock),
		.o_ok(ok_key)
	);
	assign fault = HAS_XLAT && (!ok_key || inh);

	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (as_hi && rq.memory)
					next_state = HAS_XLAT ? ST_XLAT : ST_PFILL;
			end
			ST_XLAT: begin
				// one wait state on a page miss
				if (!t_hit)
					next_state = ST_TFILL; // [RULE4]
				else if (HAS_PROT)
					next_state = ST_PFILL;
				else
					next_state = ST_DONE;
			end
			ST_TFILL: next_state = ST_XLAT;
			ST_PFILL: begin
				if (p_hit || !HAS_PROT)
					next_state = ST_DONE; // [RULE5]
			end
			ST_DONE: next_state = ST_DONE;
			default: next_state = ST_IDLE;
		endcase
		if (!as_hi)
			next_state = ST_IDLE;
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst)
			state <= ST_IDLE;
		else
			state <= next_state;
	end

	// cache fills; writes to backing memory drop copies by the tag held before the edge, so a same-cycle fill of that index keeps old data
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			tc[0] <= '0;
			tc[1] <= '0;
			pc_valid <= 1'b0;
			pc_tag <= '0;
			pc_word <= '0;
		end else begin
			if (state == ST_TFILL) begin
				tc[sel].valid <= 1'b1; // [RULE4]
				tc[sel].tag <= pidx;
				tc[sel].data <= pmem[pidx];
			end else if (state == ST_PFILL && !p_hit) begin
				pc_valid <= 1'b1; // [RULE5]
				pc_tag <= pw_idx;
				pc_word <= wmem[pw_idx];
			end
			if (i_preg_we) begin
				if (tc[0].tag == i_preg_idx)
					tc[0].valid <= 1'b0; // [RULE19]
				if (tc[1].tag == i_preg_idx)
					tc[1].valid <= 1'b0; // [RULE19]
			end
			if (i_pword_we && pc_tag == i_pword_idx)
				pc_valid <= 1'b0; // [RULE19]
		end
	end

	// backing memories hold no reset; contents come from the loader
	always_ff @(posedge i_core_clk) begin
		if (i_preg_we)
			pmem[i_preg_idx] <= mbp_preg_t'(i_preg_data);
		if (i_pword_we)
			wmem[i_pword_idx] <= i_pword_data;
	end

	wire in_check = state == ST_DONE;
	// low while strobe low; rises only on a clean result
	wire next_mpro = as_hi && in_check && !fault &&
		!(HAS_PROT && prot_bit); // [RULE9] [RULE10] [RULE11] [RULE12]
	// command cycles never flag parity
	wire next_par = !(in_check && HAS_XLAT && rq.memory &&
		par_bad); // [RULE7] [RULE8]
	wire next_pv = !(HAS_PROT && in_check); // [RULE14]
	wire next_wait = state == ST_TFILL ||
		(state == ST_PFILL && !p_hit && HAS_PROT);

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_memory_protect_out_n <= 1'b0;
			o_parity_error_out_n <= 1'b1;
			o_protect_valid_n <= 1'b1;
			o_wait <= 1'b0;
			o_phys_addr <= '0;
		end else begin
			o_memory_protect_out_n <= next_mpro;
			o_parity_error_out_n <= next_par;
			o_protect_valid_n <= next_pv;
			o_wait <= next_wait;
			o_phys_addr <= phys;
		end
	end

	strobe_low_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		!as_hi |=> !o_memory_protect_out_n) // [RULE9]
		else $error("protect output high with strobe low");
	no_prot_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		!HAS_PROT |-> o_protect_valid_n) // [RULE14]
		else $error("protect valid fell without protection");
	fault_low_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		in_check && fault |=> !o_memory_protect_out_n) // [RULE10] [RULE11]
		else $error("protect output rose on bad translation");
	prot_low_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		in_check && HAS_PROT && prot_bit |=> !o_memory_protect_out_n) // [RULE12] [RULE16]
		else $error("protected write not flagged");
	io_parity_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		!rq.memory |=> o_parity_error_out_n) // [RULE8]
		else $error("parity flagged on command cycle");
	sequence s_miss;
		state == ST_XLAT && !t_hit && as_hi;
	endsequence
	tmiss_wait_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		s_miss |=> state == ST_TFILL ##1 o_wait) // [RULE4]
		else $error("page miss without one wait");
	hit_fast_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		state == ST_XLAT && t_hit && !HAS_PROT && as_hi |=> in_check) // [RULE6]
		else $error("hit did not finish next cycle");
	pv_valid_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		HAS_PROT && in_check |=> !o_protect_valid_n) // [RULE14]
		else $error("protect valid not low at result");
	sel_pick_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		rq.dma |-> sel == rq.read) // [RULE3]
		else $error("dma cache pick wrong");
endmodule : mbp_cache_protect
`default_nettype wire

// ==== mbp_master.sv ====
// partner model: master driving strobe, state, key and selects
`timescale 1ns/1ps
`default_nettype none
module mbp_master (
	input wire logic i_core_clk,
	input wire logic i_mpro_n,
	input wire logic i_par_n,
	input wire logic i_pv_n,
	input wire logic i_wait,
	input wire logic [19:0] i_phys,
	output logic o_strobe,
	output logic o_mem,
	output logic o_rw,
	output logic o_oi,
	output logic o_dma,
	output logic [3:0] o_state,
	output logic [3:0] o_key,
	output logic [15:0] o_addr
);
	logic ok, saw_wait, par_n, pv_n, mpro_after;
	logic [19:0] phys;
	initial begin
		{o_strobe, o_mem, o_rw, o_oi, o_dma} = 5'h00;
		{o_state, o_key, o_addr} = 24'h00_0000;
	end
	// fields held while strobe high; inverted once released
	task automatic access(input logic d, mem, input logic [3:0] st, ky,
		input logic op, rd, input logic [15:0] a);
		@(posedge i_core_clk);
		#1;
		o_dma = d;
		o_state = st;
		o_key = ky;
		o_oi = op;
		o_rw = rd;
		o_mem = mem;
		o_addr = a;
		o_strobe = 1'b1;
		saw_wait = 1'b0;
		repeat (24) begin
			@(posedge i_core_clk);
			#1;
			saw_wait = saw_wait | i_wait;
		end
		ok = i_mpro_n & ~i_pv_n; // masks glitches
		par_n = i_par_n;
		pv_n = i_pv_n;
		phys = i_phys;
		o_strobe = 1'b0;
		{o_dma, o_oi, o_rw, o_mem} = ~{d, op, rd, mem};
		{o_state, o_key, o_addr} = ~{st, ky, a};
		repeat (4) @(posedge i_core_clk);
		#1;
		mpro_after = i_mpro_n;
	endtask : access
endmodule : mbp_master
`default_nettype wire

// ==== mbp_cache_protect_test.sv ====
// bench for the translation and protection cache block
`timescale 1ns/1ps
`default_nettype none
module mbp_cache_protect_test import mbp_pkg::*; ;
	typedef struct packed {
		logic [3:0] key;
		logic op;
		logic rd;
		logic [15:0] addr;
		logic ok;
		logic [7:0] ppa;
	} mbp_row_t;
	logic clk = 1'b0, rst = 1'b1, preg_we = 1'b0, pword_we = 1'b0;
	logic [8:0] preg_idx = 9'h000;
	logic [13:0] preg_data = 14'h0000;
	logic [5:0] pword_idx = 6'h00;
	logic [15:0] pword_data = 16'h0000;
	logic strobe, mem, rw, oi, dma, mpro_n, par_n, pv_n, wt;
	logic [3:0] st, ky;
	logic [15:0] addr;
	logic [19:0] phys;
	mbp_row_t r;
	int mismatches = 0, cmp_count = 0, cycles = 0;
	mbp_row_t rows [7] = '{
		'{4'h5, 1'b1, 1'b1, 16'h2000, 1'b1, 8'h35},
		'{4'h0, 1'b1, 1'b0, 16'h2400, 1'b1, 8'h35},
		'{4'h0, 1'b1, 1'b0, 16'h2000, 1'b0, 8'h35},
		'{4'h6, 1'b1, 1'b1, 16'h2000, 1'b0, 8'h35},
		'{4'h9, 1'b0, 1'b1, 16'h2abc, 1'b1, 8'h47},
		'{4'h5, 1'b1, 1'b0, 16'h4010, 1'b0, 8'h50},
		'{4'h5, 1'b1, 1'b1, 16'h4010, 1'b1, 8'h50}
	};
	always #2 clk = ~clk;
	mbp_master m (.i_core_clk(clk), .i_mpro_n(mpro_n), .i_par_n(par_n),
		.i_pv_n(pv_n), .i_wait(wt), .i_phys(phys), .o_strobe(strobe),
		.o_mem(mem), .o_rw(rw), .o_oi(oi), .o_dma(dma), .o_state(st),
		.o_key(ky), .o_addr(addr));
	mbp_cache_protect dut (.i_core_clk(clk), .i_rst(rst),
		.i_address_strobe_in(strobe), .i_memory_sel(mem),
		.i_read_write_select(rw), .i_operand_instruction_select(oi),
		.i_dma(dma), .i_address_state(st), .i_processor_state_key(ky),
		.i_addr(addr), .i_phys_ext(20'h0_0000), .i_preg_we(preg_we),
		.i_preg_idx(preg_idx), .i_preg_data(preg_data),
		.i_pword_we(pword_we), .i_pword_idx(pword_idx),
		.i_pword_data(pword_data), .o_memory_protect_out_n(mpro_n),
		.o_parity_error_out_n(par_n), .o_protect_valid_n(pv_n),
		.o_wait(wt), .o_phys_addr(phys));
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : close_out
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			mismatches++;
			close_out();
		end
	end
	task automatic check(input logic [31:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: %h expected %h", $time, seen, exp);
		end
	endtask : check
	// even parity; bad flips it to plant a fault
	function automatic logic [15:0] pr(input logic [7:0] p,
		input logic [3:0] l, input logic inh, bad);
		return {2'b00, p, l, inh, ^{p, l, inh} ^ bad};
	endfunction : pr
	task automatic wr(input logic pw, input logic [8:0] ix,
		input logic [15:0] d);
		@(posedge clk);
		#1;
		preg_we = ~pw;
		pword_we = pw;
		preg_idx = ix;
		pword_idx = ix[5:0];
		preg_data = d[13:0];
		pword_data = d;
		@(posedge clk);
		#1;
		{preg_we, pword_we} = 2'b00;
	endtask : wr
	initial begin
		repeat (2) @(posedge clk);
		#1;
		rst = 1'b0;
		check({mpro_n, par_n, pv_n, wt}, 4'h6);
		wr(1'b0, 9'h032, pr(8'h35, 4'h5, 1'b0, 1'b0));
		wr(1'b0, 9'h022, pr(8'h47, 4'hf, 1'b0, 1'b0));
		wr(1'b0, 9'h034, pr(8'h50, 4'h5, 1'b1, 1'b0));
		wr(1'b0, 9'h035, pr(8'h60, 4'h0, 1'b0, 1'b1));
		wr(1'b1, 9'h00d, 16'h0800);
		wr(1'b1, 9'h011, 16'h0000);
		wr(1'b1, 9'h014, 16'h0000);
		wr(1'b1, 9'h018, 16'h0000);
		foreach (rows[i]) begin
			r = rows[i];
			m.access(1'b0, 1'b1, 4'h1, r.key, r.op, r.rd, r.addr);
			check({m.ok, m.par_n, m.mpro_after}, {r.ok, 2'b10});
			if (r.ok)
				check({m.phys, m.pv_n}, {r.ppa, r.addr[11:0], 1'b0});
			$display("row %0d done", i);
		end
		m.access(1'b0, 1'b1, 4'h1, 4'h5, 1'b1, 1'b1, 16'h2000);
		check(m.saw_wait, 1'b1);
		m.access(1'b0, 1'b1, 4'h1, 4'h5, 1'b1, 1'b1, 16'h2000);
		check({m.ok, m.saw_wait}, 2'b10);
		$display("cache wait test done");
		m.access(1'b0, 1'b1, 4'h1, 4'h5, 1'b1, 1'b1, 16'h4123);
		check({m.ok, m.phys}, {1'b1, 20'h5_0123});
		wr(1'b0, 9'h034, pr(8'h51, 4'h5, 1'b0, 1'b0));
		m.access(1'b0, 1'b1, 4'h1, 4'h5, 1'b1, 1'b0, 16'h4123);
		check({m.ok, m.phys}, {1'b1, 20'h5_1123});
		$display("rewrite test done");
		m.access(1'b0, 1'b1, 4'h1, 4'h0, 1'b1, 1'b1, 16'h5000);
		check(m.par_n, 1'b0);
		m.access(1'b0, 1'b0, 4'h1, 4'h0, 1'b1, 1'b1, 16'h5000);
		check(m.par_n, 1'b1);
		$display("parity test done");
		m.access(1'b1, 1'b1, 4'h1, 4'h5, 1'b1, 1'b1, 16'h2010);
		check({m.ok, m.phys}, {1'b1, 20'h3_5010});
		m.access(1'b1, 1'b1, 4'h1, 4'h0, 1'b1, 1'b0, 16'h2400);
		check(m.ok, 1'b1);
		$display("dma test done");
		close_out();
	end
endmodule : mbp_cache_protect_test
`default_nettype wire
